// ==== hw/tri_bus_reset_pkg.sv ====
package tri_bus_reset_pkg;

    // =========================================================
    // Ports, indexed the same way in every vector
    // =========================================================
    localparam int NUM_PORTS = 3;
    localparam int PORT_PROC = 0;
    localparam int PORT_PCI_A = 1;
    localparam int PORT_PCI_B = 2;

    // Processor bus reset pin is open drain, PCI pins are tristate
    localparam logic [2:0] OPEN_DRAIN_MASK = 3'h1;

    // =========================================================
    // Synchroniser depth and input vector layout
    // =========================================================
    localparam int SYNC_STAGES = 2;
    localparam int SYNC_WIDTH = 14;
    localparam int SYNC_SENSE_LSB = 0;
    localparam int SYNC_DIR_LSB = 3;
    localparam int SYNC_RANGE_LSB = 6;
    localparam int SYNC_LOCK_LSB = 9;
    localparam int SYNC_BYPASS = 12;
    localparam int SYNC_BOARD = 13;
    // Reset pins idle high, board status idles in reset
    localparam logic [13:0] SYNC_INIT = 14'h2007;

    // =========================================================
    // Sequencer states and reset values
    // =========================================================
    typedef enum logic [1:0] {
        ST_PLL_RST = 2'h0,
        ST_LOCK_WAIT = 2'h1,
        ST_RUN = 2'h2
    } seq_state_e;

    typedef struct packed {
        seq_state_e state;
        logic [2:0] pll_range;
        logic pll_bypass;
        logic pll_reset;
        logic [2:0] bus_assert;
        logic [2:0] bus_out;
        logic [2:0] bus_oe;
        logic outputs_hiz;
        logic scan_normal;
    } seq_s;

    localparam logic [2:0] RANGE_RESET = 3'h0;
    localparam logic [2:0] BUS_OUT_RESET = 3'h7;
    localparam logic [2:0] BUS_OE_RESET = 3'h0;
    localparam logic [2:0] BUS_ASSERT_RESET = 3'h7;

endpackage

// ==== hw/sync_2ff.sv ====
`timescale 1ns/10ps
// Flip-flop chain; also serves as reset synchroniser (d tied high)
module sync_2ff #(
    parameter int STAGES = 2,
    parameter logic INIT = 1'b0
) (
    // Clock and asynchronous clear
    input wire logic clk,
    input wire logic arst_n,
    // Data
    input wire logic d,
    output logic q
);

    logic [STAGES-1:0] chain;

    // =========================================================
    // Chain
    // =========================================================
    // Clear asserts at once, release ripples through the chain
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chain <= {STAGES{INIT}};
        end else begin
            chain <= {chain[STAGES-2:0], d};
        end
    end

    assign q = chain[STAGES-1];

endmodule

// ==== hw/tri_bus_reset_clock_control.sv ====
`timescale 1ns/10ps
// Function
// - Power-on or board fault resets everything but the test controller reset
// - Bus reset hits own port, core only
// - Pin reset effect ignores pin direction
// - Driven pins still sensed, hold port reset
// - Only input-strapped pins propagate reset
// - Reset inputs taken asynchronously
// - PLLs reset only by power-on, board fault
// - Core, port registers and driven resets held until PLL lock or bypass
// - Board fault floats outputs, ignores inputs
// - Test reset clears scan, normal configuration
// - Processor reset driven from power-on, PCI inputs
// - First PCI reset driven from others
// - Second PCI reset driven from others
// - Driven resets released only after PLL lock, unless PLLs bypassed
// - Each port clocked through own PLL
// - PLL range from dedicated strap per port
// - Power-up option bypasses all PLLs
// - Direction strap low input, high output
// - Resets active low except board status and PLL resets
module tri_bus_reset_clock_control #(
    parameter int SYNC_STAGES = tri_bus_reset_pkg::SYNC_STAGES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Global reset pins
    input wire logic power_on_reset_n,
    input wire logic board_n_a,
    input wire logic trst_n,
    // Processor bus reset pin
    input wire logic proc_bus_reset_n_sense,
    output logic proc_bus_reset_n_drive,
    output logic proc_bus_reset_n_oe,
    // First PCI reset pin
    input wire logic pci_a_reset_n_sense,
    output logic pci_a_reset_n_drive,
    output logic pci_a_reset_n_oe,
    // Second PCI reset pin
    input wire logic pci_b_reset_n_sense,
    output logic pci_b_reset_n_drive,
    output logic pci_b_reset_n_oe,
    // Straps
    input wire logic proc_bus_reset_dir,
    input wire logic pci_a_reset_dir,
    input wire logic pci_b_reset_dir,
    input wire logic proc_bus_fast_range,
    input wire logic pci_a_66mhz_sel,
    input wire logic pci_b_66mhz_sel,
    input wire logic pll_bypass_opt,
    // PLL control, index 0 processor, 1 and 2 PCI
    input wire logic [2:0] pll_lock,
    output logic [2:0] pll_reset,
    output logic [2:0] pll_range,
    output logic pll_bypass,
    // Internal resets
    output logic proc_bus_regs_reset_n,
    output logic pci_a_regs_reset_n,
    output logic pci_b_regs_reset_n,
    output logic core_reset_n,
    // Test logic and pad control
    input wire logic tap_test_mode,
    output logic jtag_reset_n,
    output logic scan_normal,
    output logic outputs_hiz
);

    // =========================================================
    // Declarations
    // =========================================================
    tri_bus_reset_pkg::seq_s st;
    tri_bus_reset_pkg::seq_s next_st;
    logic [tri_bus_reset_pkg::SYNC_WIDTH-1:0] raw;
    logic [tri_bus_reset_pkg::SYNC_WIDTH-1:0] syn;
    logic [2:0] sense_pin;
    logic [2:0] sense;
    logic [2:0] dir;
    logic [2:0] range_s;
    logic [2:0] lock_s;
    logic bypass_s;
    logic board_s;
    logic hard_arst_n;
    logic hard_rst_n;
    logic [2:0] port_arst_n;
    logic [2:0] port_rst_n;
    logic run;

    assign sense_pin = {pci_b_reset_n_sense, pci_a_reset_n_sense,
                        proc_bus_reset_n_sense};

    // =========================================================
    // Input synchronisers
    // =========================================================
    // Pin levels, straps and locks gathered into one vector
    assign raw = {board_n_a, pll_bypass_opt, pll_lock,
                  pci_b_66mhz_sel, pci_a_66mhz_sel, proc_bus_fast_range,
                  pci_b_reset_dir, pci_a_reset_dir, proc_bus_reset_dir,
                  sense_pin};

    // Two flops per pin before the sequencer looks at it; reset logic takes the raw pins
    for (genvar i = 0; i < tri_bus_reset_pkg::SYNC_WIDTH; i++) begin : g_in
        sync_2ff #(
            .STAGES(SYNC_STAGES),
            .INIT(tri_bus_reset_pkg::SYNC_INIT[i])
        ) u_sync (
            .clk(clk),
            .arst_n(arst_n),
            .d(raw[i]),
            .q(syn[i])
        );
    end

    assign board_s = syn[tri_bus_reset_pkg::SYNC_BOARD];
    assign bypass_s = syn[tri_bus_reset_pkg::SYNC_BYPASS];
    assign dir = syn[tri_bus_reset_pkg::SYNC_DIR_LSB +: 3];
    assign range_s = syn[tri_bus_reset_pkg::SYNC_RANGE_LSB +: 3];
    assign lock_s = syn[tri_bus_reset_pkg::SYNC_LOCK_LSB +: 3];
    // Inputs ignored while the board is unhealthy
    assign sense = syn[tri_bus_reset_pkg::SYNC_SENSE_LSB +: 3]
                   | {3{board_s}};

    // =========================================================
    // Reset synchronisers
    // =========================================================
    // Power-on low or board status high: active low, high
    assign hard_arst_n = arst_n & power_on_reset_n
                         & ~board_n_a;

    // Asserts without a clock, releases on clk
    sync_2ff #(
        .STAGES(SYNC_STAGES),
        .INIT(1'b0)
    ) u_hard (
        .clk(clk),
        .arst_n(hard_arst_n),
        .d(1'b1),
        .q(hard_rst_n)
    );

    assign run = st.state == tri_bus_reset_pkg::ST_RUN;

    // Per-port register resets, pin low regardless of direction
    for (genvar p = 0; p < tri_bus_reset_pkg::NUM_PORTS; p++) begin : g_port
        assign port_arst_n[p] = hard_arst_n & sense_pin[p];
        sync_2ff #(
            .STAGES(SYNC_STAGES),
            .INIT(1'b0)
        ) u_port (
            .clk(clk),
            .arst_n(port_arst_n[p]),
            .d(run),
            .q(port_rst_n[p])
        );
    end

    assign proc_bus_regs_reset_n = port_rst_n[tri_bus_reset_pkg::PORT_PROC];
    assign pci_a_regs_reset_n = port_rst_n[tri_bus_reset_pkg::PORT_PCI_A];
    assign pci_b_regs_reset_n = port_rst_n[tri_bus_reset_pkg::PORT_PCI_B];

    // Device registers and state machines follow any pin reset
    sync_2ff #(
        .STAGES(SYNC_STAGES),
        .INIT(1'b0)
    ) u_core (
        .clk(clk),
        .arst_n(&port_arst_n),
        .d(run),
        .q(core_reset_n)
    );

    // Test controller reset, caught asynchronously
    sync_2ff #(
        .STAGES(SYNC_STAGES),
        .INIT(1'b0)
    ) u_jtag (
        .clk(clk),
        .arst_n(arst_n & trst_n),
        .d(1'b1),
        .q(jtag_reset_n)
    );

    // =========================================================
    // Sequencer next state
    // =========================================================
    always_comb begin
        next_st = st;
        unique case (st.state)
            tri_bus_reset_pkg::ST_PLL_RST: begin
                // Straps taken as power-on reset releases
                if (hard_rst_n) begin
                    next_st.pll_range = range_s;
                    next_st.pll_bypass = bypass_s;
                    next_st.pll_reset = 1'b0;
                    next_st.state = tri_bus_reset_pkg::ST_LOCK_WAIT;
                end
            end
            tri_bus_reset_pkg::ST_LOCK_WAIT: begin
                // Every PLL must lock unless bypassed
                if (&lock_s || st.pll_bypass) begin
                    next_st.state = tri_bus_reset_pkg::ST_RUN;
                end
            end
            tri_bus_reset_pkg::ST_RUN: begin
                next_st.state = tri_bus_reset_pkg::ST_RUN;
            end
            default: begin
                next_st.state = tri_bus_reset_pkg::ST_PLL_RST;
            end
        endcase
        // Only the hard reset puts the PLLs back into reset
        if (!hard_rst_n) begin
            next_st.state = tri_bus_reset_pkg::ST_PLL_RST;
            next_st.pll_reset = 1'b1;
        end

        // Reset generation toward each bus
        for (int i = 0; i < tri_bus_reset_pkg::NUM_PORTS; i++) begin
            logic prop;
            prop = 1'b0;
            for (int j = 0; j < tri_bus_reset_pkg::NUM_PORTS; j++) begin
                // Dir low is input, only inputs propagate
                if (j != i && !dir[j] && !sense[j]) begin
                    prop = 1'b1;
                end
            end
            // Power-on, then until lock or bypass, keeps driven outputs low
            next_st.bus_assert[i] = dir[i] & (!run | prop);
            if (tri_bus_reset_pkg::OPEN_DRAIN_MASK[i]) begin
                next_st.bus_out[i] = 1'b0;
                next_st.bus_oe[i] = next_st.bus_assert[i] & ~board_s;
            end else begin
                next_st.bus_out[i] = ~next_st.bus_assert[i];
                next_st.bus_oe[i] = dir[i] & ~board_s;
            end
        end
        next_st.outputs_hiz = board_s;

        // Scan in normal configuration after test reset
        next_st.scan_normal = !jtag_reset_n | ~tap_test_mode;
    end

    // =========================================================
    // Sequencer state
    // =========================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '{state: tri_bus_reset_pkg::ST_PLL_RST,
                    pll_range: tri_bus_reset_pkg::RANGE_RESET,
                    pll_bypass: 1'b0,
                    pll_reset: 1'b1,
                    bus_assert: tri_bus_reset_pkg::BUS_ASSERT_RESET,
                    bus_out: tri_bus_reset_pkg::BUS_OUT_RESET,
                    bus_oe: tri_bus_reset_pkg::BUS_OE_RESET,
                    outputs_hiz: 1'b1,
                    scan_normal: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    // One PLL per port clock, all share the sequencer
    assign pll_reset = {3{st.pll_reset}};
    assign pll_range = st.pll_range;
    assign pll_bypass = st.pll_bypass;
    assign proc_bus_reset_n_drive = st.bus_out[tri_bus_reset_pkg::PORT_PROC];
    assign proc_bus_reset_n_oe = st.bus_oe[tri_bus_reset_pkg::PORT_PROC];
    assign pci_a_reset_n_drive = st.bus_out[tri_bus_reset_pkg::PORT_PCI_A];
    assign pci_a_reset_n_oe = st.bus_oe[tri_bus_reset_pkg::PORT_PCI_A];
    assign pci_b_reset_n_drive = st.bus_out[tri_bus_reset_pkg::PORT_PCI_B];
    assign pci_b_reset_n_oe = st.bus_oe[tri_bus_reset_pkg::PORT_PCI_B];
    assign outputs_hiz = st.outputs_hiz;
    assign scan_normal = st.scan_normal;

    // =========================================================
    // Checks
    // =========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_hard_release;
        st.state == tri_bus_reset_pkg::ST_PLL_RST && hard_rst_n;
    endsequence

    sequence s_locked_wait;
        st.state == tri_bus_reset_pkg::ST_LOCK_WAIT && (&lock_s);
    endsequence

    chk_pll_hard_only: assert property (
        st.pll_reset |-> !$past(hard_rst_n) ||
            $past(st.state) == tri_bus_reset_pkg::ST_PLL_RST)
        else $error("PLL reset without hard reset");

    chk_core_after_run: assert property (
        core_reset_n && hard_rst_n |-> run)
        else $error("Core released before lock");

    chk_lock_to_run: assert property (
        s_locked_wait and hard_rst_n |=> run)
        else $error("Lock did not start run");

    chk_range_capture: assert property (
        s_hard_release |=> pll_range == $past(range_s) &&
            st.state == tri_bus_reset_pkg::ST_LOCK_WAIT)
        else $error("Range strap not captured");

    chk_proc_drive: assert property (
        dir[0] && !board_s && !run |=>
            proc_bus_reset_n_oe && !proc_bus_reset_n_drive)
        else $error("Processor reset not driven");

    chk_pci_a_prop: assert property (
        run && dir[1] && !dir[2] && !sense[2] && !board_s |=>
            pci_a_reset_n_oe && !pci_a_reset_n_drive)
        else $error("First PCI reset not propagated");

    chk_pci_b_prop: assert property (
        run && dir[2] && !dir[0] && !sense[0] && !board_s |=>
            pci_b_reset_n_oe && !pci_b_reset_n_drive)
        else $error("Second PCI reset not propagated");

    chk_no_out_prop: assert property (
        run && !board_s && (dir[1] || sense[1]) && (dir[2] || sense[2])
            |=> !proc_bus_reset_n_oe)
        else $error("Output pin reset propagated");

    chk_hold_till_lock: assert property (
        st.state == tri_bus_reset_pkg::ST_LOCK_WAIT && dir[1] && !board_s
            |=> !pci_a_reset_n_drive)
        else $error("PCI reset released before lock");

    chk_board_float: assert property (
        board_s |=> outputs_hiz && st.bus_oe == 3'h0)
        else $error("Outputs driven while board unhealthy");

    chk_scan_normal: assert property (
        !jtag_reset_n |=> scan_normal)
        else $error("Scan not normal after test reset");

endmodule

// ==== dv/board_model.sv ====
`timescale 1ns/10ps
// Board side: pulled-up reset wires, bus agents, PLL macros
module board_model (
    // Clock
    input wire logic clk,
    // Reset wires, index 0 processor, 1 and 2 PCI
    input wire logic [2:0] agent_pull,
    input wire logic [2:0] pin_drive,
    input wire logic [2:0] pin_oe,
    output logic [2:0] pin_level,
    // PLL macros
    input wire logic [2:0] pll_reset,
    input wire logic [7:0] lock_delay,
    output logic [2:0] pll_lock
);
    logic [7:0] lock_cnt;

    // =========================================================
    // Reset wires
    // =========================================================
    // Wired low with pull-ups, so a released wire reads high
    assign pin_level = ~(agent_pull | (pin_oe & ~pin_drive));

    // =========================================================
    // PLL lock
    // =========================================================
    // Lock a set number of cycles after the PLLs leave reset
    always @(posedge clk) begin
        if (pll_reset[0]) begin
            lock_cnt <= 8'h00;
        end else if (lock_cnt != 8'hFF) begin
            lock_cnt <= lock_cnt + 8'h01;
        end
    end
    // Each PLL locks a little later than the one before it
    for (genvar i = 0; i < 3; i++) begin : g_lock
        assign pll_lock[i] = !pll_reset[i]
            && (int'(lock_cnt) >= int'(lock_delay) + 8 * i);
    end
endmodule

// ==== dv/tb_tri_bus_reset_clock_control.sv ====
`timescale 1ns/10ps
`define CHK(what, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("MISMATCH %s expected %h seen %h", what, exp, got); \
        end \
    end

module tb_tri_bus_reset_clock_control;
    logic clk = 1'b0;
    logic arst_n;
    logic power_on_reset_n;
    logic board_n_a;
    logic trst_n;
    logic [2:0] dir;
    logic [2:0] range_sel;
    logic bypass_opt;
    logic tap_test_mode;
    logic [2:0] agent_pull;
    logic [7:0] lock_delay;
    logic [2:0] sense;
    logic [2:0] drive;
    logic [2:0] oe;
    logic [2:0] pll_lock;
    logic [2:0] pll_reset;
    logic [2:0] pll_range;
    logic pll_bypass;
    logic [2:0] regs_n;
    logic core_reset_n;
    logic jtag_reset_n;
    logic scan_normal;
    logic outputs_hiz;
    int err_total = 0;
    int num_checks = 0;

    // =========================================================
    // Design and board
    // =========================================================
    tri_bus_reset_clock_control dut (
        .clk(clk), .arst_n(arst_n),
        .power_on_reset_n(power_on_reset_n), .board_n_a(board_n_a),
        .trst_n(trst_n),
        .proc_bus_reset_n_sense(sense[0]),
        .proc_bus_reset_n_drive(drive[0]), .proc_bus_reset_n_oe(oe[0]),
        .pci_a_reset_n_sense(sense[1]),
        .pci_a_reset_n_drive(drive[1]), .pci_a_reset_n_oe(oe[1]),
        .pci_b_reset_n_sense(sense[2]),
        .pci_b_reset_n_drive(drive[2]), .pci_b_reset_n_oe(oe[2]),
        .proc_bus_reset_dir(dir[0]), .pci_a_reset_dir(dir[1]),
        .pci_b_reset_dir(dir[2]), .proc_bus_fast_range(range_sel[0]),
        .pci_a_66mhz_sel(range_sel[1]), .pci_b_66mhz_sel(range_sel[2]),
        .pll_bypass_opt(bypass_opt), .pll_lock(pll_lock),
        .pll_reset(pll_reset), .pll_range(pll_range),
        .pll_bypass(pll_bypass), .proc_bus_regs_reset_n(regs_n[0]),
        .pci_a_regs_reset_n(regs_n[1]), .pci_b_regs_reset_n(regs_n[2]),
        .core_reset_n(core_reset_n), .tap_test_mode(tap_test_mode),
        .jtag_reset_n(jtag_reset_n), .scan_normal(scan_normal),
        .outputs_hiz(outputs_hiz)
    );

    board_model board (
        .clk(clk), .agent_pull(agent_pull), .pin_drive(drive),
        .pin_oe(oe), .pin_level(sense), .pll_reset(pll_reset),
        .lock_delay(lock_delay), .pll_lock(pll_lock)
    );

    // Free-running clock, up before power-on release
    always #10 clk = ~clk;

    // =========================================================
    // Helpers
    // =========================================================
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic summarize();
        $display("Checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Bounded wait for the core to leave reset
    task automatic wait_run(input int bound);
        int i;
        i = 0;
        while (core_reset_n !== 1'b1 && i < bound) begin
            step(1);
            i++;
        end
        if (core_reset_n !== 1'b1) begin
            err_total++;
            $display("MISMATCH run_reached expected 1 seen %b", core_reset_n);
            summarize();
        end else begin
            step(2);
        end
    endtask

    // Power-on reset with new straps, then release
    task automatic power_up(input logic [2:0] dirs, input logic [2:0] rng,
                            input logic byp, input logic [7:0] dly);
        power_on_reset_n = 1'b0;
        trst_n = 1'b0;
        dir = dirs;
        range_sel = rng;
        bypass_opt = byp;
        lock_delay = dly;
        step(6);
        `CHK("pll_reset_por", 3'h7, pll_reset)
        `CHK("core_por", 1'b0, core_reset_n)
        `CHK("pins_por", ~dirs, sense)
        power_on_reset_n = 1'b1;
        trst_n = 1'b1;
    endtask

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic test_power_up();
        power_up(3'h6, 3'h5, 1'b0, 8'd40);
        step(20);
        `CHK("pll_out_of_reset", 3'h0, pll_reset)
        `CHK("core_before_lock", 1'b0, core_reset_n)
        `CHK("pins_before_lock", 3'h1, sense)
        step(32);
        `CHK("lock_partial", 3'h3, pll_lock)
        `CHK("core_part_lock", 1'b0, core_reset_n)
        wait_run(100);
        `CHK("port_resets_run", 3'h7, regs_n)
        `CHK("pins_after_lock", 3'h7, sense)
        `CHK("oe_run", 3'h6, oe)
        `CHK("range_captured", 3'h5, pll_range)
        `CHK("bypass_off", 1'b0, pll_bypass)
        $display("test_power_up done");
    endtask

    task automatic test_input_pin();
        agent_pull = 3'h1;
        step(6);
        `CHK("proc_regs_in", 1'b0, regs_n[0])
        `CHK("pci_regs_in", 2'h0, regs_n[2:1])
        `CHK("core_in", 1'b0, core_reset_n)
        `CHK("pll_kept", 3'h0, pll_reset)
        `CHK("pci_forwarded", 3'h0, sense)
        agent_pull = 3'h0;
        step(8);
        `CHK("resets_back", 4'hF, {core_reset_n, regs_n})
        $display("test_input_pin done");
    endtask

    task automatic test_output_pin();
        agent_pull = 3'h2;
        step(6);
        `CHK("pci_a_regs", 1'b0, regs_n[1])
        `CHK("core_out", 1'b0, core_reset_n)
        `CHK("other_regs", 2'h3, {regs_n[2], regs_n[0]})
        `CHK("no_forward", 3'h5, sense)
        `CHK("oe_held", 3'h6, oe)
        agent_pull = 3'h0;
        step(8);
        $display("test_output_pin done");
    endtask

    task automatic test_board_fault();
        agent_pull = 3'h1;
        board_n_a = 1'b1;
        #1;
        `CHK("core_async", 1'b0, core_reset_n)
        step(6);
        `CHK("hiz", 1'b1, outputs_hiz)
        `CHK("oe_off", 3'h0, oe)
        `CHK("pll_reset_fault", 3'h7, pll_reset)
        `CHK("regs_fault", 3'h0, regs_n)
        agent_pull = 3'h0;
        board_n_a = 1'b0;
        step(10);
        `CHK("core_relock", 1'b0, core_reset_n)
        wait_run(100);
        `CHK("hiz_off", 1'b0, outputs_hiz)
        `CHK("pins_fault_done", 3'h7, sense)
        $display("test_board_fault done");
    endtask

    task automatic test_bypass_swap();
        power_up(3'h3, 3'h2, 1'b1, 8'hF0);
        wait_run(60);
        `CHK("bypass_on", 1'b1, pll_bypass)
        `CHK("range_swap", 3'h2, pll_range)
        agent_pull = 3'h4;
        step(6);
        `CHK("proc_oe_from_b", 3'h3, oe)
        `CHK("fwd_from_b", 3'h0, sense)
        agent_pull = 3'h0;
        step(8);
        agent_pull = 3'h2;
        step(6);
        `CHK("no_fwd_out", 3'h2, oe)
        `CHK("sense_out", 3'h5, sense)
        `CHK("regs_out", 3'h5, regs_n)
        agent_pull = 3'h0;
        step(8);
        $display("test_bypass_swap done");
    endtask

    task automatic test_jtag();
        tap_test_mode = 1'b1;
        step(4);
        `CHK("scan_test", 1'b0, scan_normal)
        trst_n = 1'b0;
        step(4);
        `CHK("jtag_rst", 1'b0, jtag_reset_n)
        `CHK("scan_norm", 1'b1, scan_normal)
        trst_n = 1'b1;
        tap_test_mode = 1'b0;
        step(4);
        $display("test_jtag done");
    endtask

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        arst_n = 1'b0;
        power_on_reset_n = 1'b0;
        board_n_a = 1'b0;
        trst_n = 1'b0;
        dir = 3'h6;
        range_sel = 3'h0;
        bypass_opt = 1'b0;
        tap_test_mode = 1'b0;
        agent_pull = 3'h0;
        lock_delay = 8'd40;
        step(2);
        arst_n = 1'b1;
        test_power_up();
        test_input_pin();
        test_output_pin();
        test_board_fault();
        test_jtag();
        test_bypass_swap();
        summarize();
    end
endmodule
